// File: inc/ohci_list_pkg.sv
// Offsets, field positions, reset values and timing of the list control registers
`default_nettype none
package ohci_list_pkg;
  localparam logic [7:0] CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] COMMAND_OFFSET = 8'h08;
  localparam int RATIO_LSB = 0;
  localparam int PERIODIC_ENABLE_BIT = 2;
  localparam int ISO_ENABLE_BIT = 3;
  localparam int CONTROL_ENABLE_BIT = 4;
  localparam int RESET_REQ_BIT = 0;
  localparam int CONTROL_FILLED_BIT = 1;
  localparam int BULK_FILLED_BIT = 2;
  localparam int OWNERSHIP_REQ_BIT = 3;
  localparam int OVERRUN_COUNT_LSB = 16;
  localparam logic [1:0] RATIO_RESET = 2'h0;
  localparam logic [1:0] OVERRUN_COUNT_RESET = 2'h0;
  localparam logic [2:0] SERVED_COUNT_RESET = 3'h0;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int SOFT_RESET_MAX_NS = 10000;
  // Longest time: round down
  localparam int SOFT_RESET_CYCLES = SOFT_RESET_MAX_NS / CLOCK_PERIOD_NS;
  localparam logic [10:0] SOFT_RESET_LOAD = 11'(SOFT_RESET_CYCLES - 1);
  localparam logic [10:0] SOFT_RESET_ZERO = 11'h000;
endpackage : ohci_list_pkg
`default_nettype wire

// File: rtl/ohci_list_control_command_regs.sv
// List enables, service ratio and write-to-set command/status register
`default_nettype none
// How it works
// R01 - Control list runs from next frame onward
// R02 - Control enable checked at every list use
// R03 - Isochronous descriptor continues only when enabled
// R04 - Isochronous enable setting waits for next frame
// R05 - Periodic list gated per frame and checked
// R06 - Ratio 00/10/11 gives one, three, four
// R07 - Ratio 01 gives two control per bulk
// R08 - Compare served count with ratio first
// R09 - Served count survives frame boundaries
// R10 - Software rewrites ratio after any reset
// R11 - Software edits control list only disabled
// R12 - Command writes set ones, ignore zeros
// R13 - Command register reads back without effect
// R14 - Overrun bumps count and flags status
// R15 - Software writes reserved bits as zero
// R16 - Control at 04h, command at 08h
// R17 - Overrun count starts zero, wraps, always counts
// R18 - Ownership request raises ownership change flag
// R19 - Filled bits cleared at pass, set on find
// R20 - Soft reset clears registers, self-clears in time
module ohci_list_control_command_regs (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic frame_start,
  input wire logic periodic_overrun,
  input wire logic control_pass_start,
  input wire logic bulk_pass_start,
  input wire logic control_td_found,
  input wire logic bulk_td_found,
  input wire logic control_ed_served,
  input wire logic bulk_ed_served,
  input wire logic changeover_done,
  output logic control_list_run,
  output logic periodic_list_run,
  output logic iso_run,
  output logic serve_control,
  output logic sched_overrun_set,
  output logic ownership_change_set,
  output logic soft_reset_active
);
  logic control_enable;
  logic iso_enable;
  logic periodic_list_enable;
  logic [1:0] control_bulk_ratio;
  logic control_frame;
  logic iso_frame;
  logic periodic_frame;
  logic software_reset_request;
  logic control_list_filled;
  logic bulk_list_filled;
  logic ownership_change_request;
  logic [1:0] overrun_count;
  logic [2:0] served_count;
  logic [10:0] reset_timer;

  function automatic logic [2:0] ratio_limit(input logic [1:0] ratio);
    // R06 R07
    ratio_limit = {1'b0, ratio} + 3'h1;
  endfunction : ratio_limit

  // Writes are refused while a soft reset runs
  wire ctrl_hit = reg_addr == ohci_list_pkg::CONTROL_OFFSET; // R16
  wire cmd_hit = reg_addr == ohci_list_pkg::COMMAND_OFFSET; // R16
  wire ctrl_wr = reg_wr && ctrl_hit && !software_reset_request;
  wire cmd_wr = reg_wr && cmd_hit && !software_reset_request;
  wire reset_start = cmd_wr && reg_wdata[ohci_list_pkg::RESET_REQ_BIT]; // R20
  wire ops_clear = rst || reset_start; // R20
  wire reset_done = software_reset_request && reset_timer == ohci_list_pkg::SOFT_RESET_ZERO;
  wire set_clf = cmd_wr && reg_wdata[ohci_list_pkg::CONTROL_FILLED_BIT]; // R12
  wire set_blf = cmd_wr && reg_wdata[ohci_list_pkg::BULK_FILLED_BIT]; // R12
  wire set_ocr = cmd_wr && reg_wdata[ohci_list_pkg::OWNERSHIP_REQ_BIT]; // R12
  wire [31:0] ctrl_value = {27'h0000000, control_enable, iso_enable, periodic_list_enable,
                            control_bulk_ratio};
  wire [31:0] cmd_value = {14'h0000, overrun_count, 12'h000, ownership_change_request,
                           bulk_list_filled, control_list_filled, software_reset_request};
  wire [31:0] next_rdata = ctrl_hit ? ctrl_value :
                           cmd_hit ? cmd_value : ohci_list_pkg::READ_ZERO;
  // A cleared enable also drops its frame copy, so a set mid-frame waits for SOF
  wire next_control_frame = frame_start ? control_enable : control_frame && control_enable;
  wire next_iso_frame = frame_start ? iso_enable : iso_frame && iso_enable;
  wire next_periodic_frame = frame_start ? periodic_list_enable
                                         : periodic_frame && periodic_list_enable;
  wire next_serve = served_count < ratio_limit(control_bulk_ratio); // R08

  always_ff @(posedge clock) begin
    if (ops_clear) begin
      control_enable <= 1'b0;
      iso_enable <= 1'b0;
      periodic_list_enable <= 1'b0;
      control_bulk_ratio <= ohci_list_pkg::RATIO_RESET; // R10
    end else if (ctrl_wr) begin
      control_enable <= reg_wdata[ohci_list_pkg::CONTROL_ENABLE_BIT];
      iso_enable <= reg_wdata[ohci_list_pkg::ISO_ENABLE_BIT];
      periodic_list_enable <= reg_wdata[ohci_list_pkg::PERIODIC_ENABLE_BIT];
      control_bulk_ratio <= reg_wdata[ohci_list_pkg::RATIO_LSB +: 2];
    end
  end

  always_ff @(posedge clock) begin
    if (ops_clear) begin
      control_frame <= 1'b0;
      iso_frame <= 1'b0;
      periodic_frame <= 1'b0;
    end else begin
      control_frame <= next_control_frame; // R01
      iso_frame <= next_iso_frame; // R04
      periodic_frame <= next_periodic_frame; // R05
    end
  end

  // Live enable and frame copy both gate each use
  always_ff @(posedge clock) begin
    if (ops_clear) begin
      control_list_run <= 1'b0;
      periodic_list_run <= 1'b0;
      iso_run <= 1'b0;
      serve_control <= 1'b0;
    end else begin
      control_list_run <= control_enable && control_frame; // R01 R02
      periodic_list_run <= periodic_list_enable && periodic_frame; // R05
      iso_run <= iso_enable && iso_frame; // R03 R04
      serve_control <= next_serve; // R06 R08
    end
  end

  // Not touched by frame_start: the ratio spans frames
  always_ff @(posedge clock) begin
    if (ops_clear) begin
      served_count <= ohci_list_pkg::SERVED_COUNT_RESET;
    end else if (bulk_ed_served) begin
      served_count <= ohci_list_pkg::SERVED_COUNT_RESET; // R08
    end else if (control_ed_served && next_serve) begin
      served_count <= served_count + 3'h1; // R08 R09
    end
  end

  // Set beats the pass-start clear so a found TD is never lost
  always_ff @(posedge clock) begin
    if (ops_clear) begin
      control_list_filled <= 1'b0;
      bulk_list_filled <= 1'b0;
    end else begin
      control_list_filled <= set_clf || control_td_found ||
                             (control_list_filled && !control_pass_start); // R12 R19
      bulk_list_filled <= set_blf || bulk_td_found ||
                          (bulk_list_filled && !bulk_pass_start); // R12 R19
    end
  end

  always_ff @(posedge clock) begin
    if (ops_clear) begin
      ownership_change_request <= 1'b0;
      ownership_change_set <= 1'b0;
    end else begin
      ownership_change_request <= set_ocr || (ownership_change_request && !changeover_done);
      ownership_change_set <= set_ocr; // R18
    end
  end

  // Counts even if the status flag is already high; wraps 11b to 00b
  always_ff @(posedge clock) begin
    if (ops_clear) begin
      overrun_count <= ohci_list_pkg::OVERRUN_COUNT_RESET; // R17
      sched_overrun_set <= 1'b0;
    end else begin
      if (periodic_overrun) begin
        overrun_count <= overrun_count + 2'h1; // R14 R17
      end
      sched_overrun_set <= periodic_overrun; // R14
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      software_reset_request <= 1'b0;
      reset_timer <= ohci_list_pkg::SOFT_RESET_ZERO;
      soft_reset_active <= 1'b0;
    end else if (reset_start) begin
      software_reset_request <= 1'b1; // R20
      reset_timer <= ohci_list_pkg::SOFT_RESET_LOAD;
      soft_reset_active <= 1'b1;
    end else if (reset_done) begin
      software_reset_request <= 1'b0; // R20
      soft_reset_active <= 1'b0;
    end else if (software_reset_request) begin
      reset_timer <= reset_timer - 11'h001;
    end
  end

  // Plain reads: no bit changes on a read
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= ohci_list_pkg::READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata; // R13 R16
    end
  end

  logic [11:0] reset_high_cycles;
  always_ff @(posedge clock) begin
    if (rst || !software_reset_request) begin
      reset_high_cycles <= 12'h000;
    end else begin
      reset_high_cycles <= reset_high_cycles + 12'h001;
    end
  end

  sequence enable_set_at_sof;
    frame_start && control_enable && !ops_clear;
  endsequence
  sequence enable_held;
    control_enable && !ops_clear;
  endsequence
  sequence iso_set_at_sof;
    frame_start && iso_enable && !ops_clear;
  endsequence
  sequence iso_held;
    iso_enable && !ops_clear;
  endsequence
  sequence periodic_set_at_sof;
    frame_start && periodic_list_enable && !ops_clear;
  endsequence
  sequence periodic_held;
    periodic_list_enable && !ops_clear;
  endsequence

  // Engine events move command bits by themselves, so a read beside one may see a change
  wire cmd_events = periodic_overrun || control_pass_start || bulk_pass_start ||
                    control_td_found || bulk_td_found || changeover_done || reset_done;

  chk_ctrl_next_frame: assert property (@(posedge clock) disable iff (rst) // R01
    enable_set_at_sof ##1 enable_held |=> control_list_run)
    else $error("control list not running after enabled SOF");
  chk_ctrl_sampled: assert property (@(posedge clock) disable iff (rst) // R02
    !control_enable |=> !control_list_run)
    else $error("control list running while disabled");
  chk_iso_decision: assert property (@(posedge clock) disable iff (rst) // R03
    iso_run |-> $past(iso_enable))
    else $error("isochronous continue without enable");
  chk_iso_wait_frame: assert property (@(posedge clock) disable iff (rst) // R04
    $rose(iso_enable) |=> !iso_run)
    else $error("isochronous enable acted within frame");
  chk_periodic_gate: assert property (@(posedge clock) disable iff (rst) // R05
    (!periodic_list_enable || !periodic_frame) |=> !periodic_list_run)
    else $error("periodic list running without enable");
  chk_ratio_serve: assert property (@(posedge clock) disable iff (rst) // R06
    !ops_clear |=> serve_control ==
      ($past(served_count) < ({1'b0, $past(control_bulk_ratio)} + 3'h1)))
    else $error("service ratio decision wrong");
  chk_count_keep: assert property (@(posedge clock) disable iff (rst) // R09
    frame_start && !control_ed_served && !bulk_ed_served && !ops_clear |=> $stable(served_count))
    else $error("served count changed at frame start");
  chk_write_set: assert property (@(posedge clock) disable iff (rst) // R12
    cmd_wr && !reset_start && control_list_filled && !control_pass_start
    |=> control_list_filled)
    else $error("zero written cleared a command bit");
  chk_read_back: assert property (@(posedge clock) disable iff (rst) // R13
    reg_rd && cmd_hit && !reg_wr && !cmd_events
    |=> reg_rdata == $past(cmd_value) && $stable(cmd_value))
    else $error("command read wrong or had effect");
  chk_overrun_count: assert property (@(posedge clock) disable iff (rst) // R14
    periodic_overrun && !ops_clear
    |=> sched_overrun_set && overrun_count == $past(overrun_count) + 2'h1)
    else $error("overrun not counted or flagged");
  chk_ownership_flag: assert property (@(posedge clock) disable iff (rst) // R18
    set_ocr && !reset_start |=> ownership_change_set && ownership_change_request)
    else $error("ownership change flag not raised");
  chk_filled_found: assert property (@(posedge clock) disable iff (rst) // R19
    control_td_found && !ops_clear |=> control_list_filled)
    else $error("found TD did not set filled bit");
  chk_reset_bound: assert property (@(posedge clock) disable iff (rst) // R20
    reset_high_cycles <= 12'(ohci_list_pkg::SOFT_RESET_CYCLES))
    else $error("soft reset did not self-clear in time");
  chk_iso_next_frame: assert property (@(posedge clock) disable iff (rst) // R04
    iso_set_at_sof ##1 iso_held |=> iso_run)
    else $error("isochronous enable not active in next frame");
  chk_iso_halt: assert property (@(posedge clock) disable iff (rst) // R03
    !iso_enable |=> !iso_run)
    else $error("isochronous continue while disabled");
  chk_periodic_next_frame: assert property (@(posedge clock) disable iff (rst) // R05
    periodic_set_at_sof ##1 periodic_held |=> periodic_list_run)
    else $error("periodic list not running after enabled SOF");
  chk_ratio_two: assert property (@(posedge clock) disable iff (rst) // R07
    control_bulk_ratio == 2'h1 && !ops_clear |=> serve_control == ($past(served_count) < 3'h2))
    else $error("ratio two to one decision wrong");
  chk_ratio_four: assert property (@(posedge clock) disable iff (rst) // R06
    control_bulk_ratio == 2'h3 && !ops_clear |=> serve_control == ($past(served_count) < 3'h4))
    else $error("ratio four to one decision wrong");
  chk_count_bulk_clear: assert property (@(posedge clock) disable iff (rst) // R08
    bulk_ed_served && !ops_clear |=> served_count == ohci_list_pkg::SERVED_COUNT_RESET)
    else $error("served count not restarted after bulk");
  chk_overrun_wrap: assert property (@(posedge clock) disable iff (rst) // R17
    periodic_overrun && overrun_count == 2'h3 && !ops_clear |=> overrun_count == 2'h0)
    else $error("overrun count did not wrap");
  chk_filled_cleared: assert property (@(posedge clock) disable iff (rst) // R19
    control_pass_start && !control_td_found && !set_clf && !ops_clear |=> !control_list_filled)
    else $error("filled bit not cleared at pass start");
  chk_ocr_clear: assert property (@(posedge clock) disable iff (rst) // R18
    changeover_done && !set_ocr && !ops_clear |=> !ownership_change_request)
    else $error("ownership request not cleared after changeover");
  chk_soft_reset_clear: assert property (@(posedge clock) disable iff (rst) // R20
    reset_start |=> !control_enable && !control_list_filled && software_reset_request &&
    overrun_count == ohci_list_pkg::OVERRUN_COUNT_RESET)
    else $error("soft reset did not clear registers");
  chk_write_blocked: assert property (@(posedge clock) disable iff (rst) // R20
    reg_wr && software_reset_request |=> $stable(control_enable) && $stable(control_bulk_ratio))
    else $error("register write taken during soft reset");
endmodule : ohci_list_control_command_regs
`default_nettype wire

// File: test/ohci_list_control_command_regs_tb.sv
// Self-checking bench for list enables, service ratio and command/status register
`default_nettype none
module ohci_list_control_command_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] reg_rdata;
  // Event pulses from the list engine, one bit each
  logic [8:0] ev = 9'h000;
  logic control_list_run;
  logic periodic_list_run;
  logic iso_run;
  logic serve_control;
  logic sched_overrun_set;
  logic ownership_change_set;
  logic soft_reset_active;
  wire logic [31:0] runs;
  wire logic [31:0] serve;
  int fail_count = 0;
  int checks_done = 0;
  int own_seen = 0;
  int over_seen = 0;
  int cyc = 0;
  int t0;

  assign runs = {29'h00000000, control_list_run, periodic_list_run, iso_run};
  assign serve = {31'h00000000, serve_control};

  ohci_list_control_command_regs ohci_list_control_command_regs_inst (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_start(ev[0]),
    .periodic_overrun(ev[1]), .control_pass_start(ev[2]), .bulk_pass_start(ev[3]),
    .control_td_found(ev[4]), .bulk_td_found(ev[5]), .control_ed_served(ev[6]),
    .bulk_ed_served(ev[7]), .changeover_done(ev[8]), .control_list_run(control_list_run),
    .periodic_list_run(periodic_list_run), .iso_run(iso_run), .serve_control(serve_control),
    .sched_overrun_set(sched_overrun_set), .ownership_change_set(ownership_change_set),
    .soft_reset_active(soft_reset_active)
  );

  initial begin
    forever #2.5 clock = ~clock;
  end

  // Pulses are counted rather than timed, so one-cycle skew cannot hide them
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (ownership_change_set === 1'b1) own_seen <= own_seen + 1;
    if (sched_overrun_set === 1'b1) over_seen <= over_seen + 1;
  end

  task automatic end_of_test;
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    #1 chk(reg_rdata, exp);
  endtask : rd

  task automatic pulse(input int n);
    @(posedge clock);
    ev[n] <= 1'b1;
    @(posedge clock);
    ev[n] <= 1'b0;
  endtask : pulse

  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd(8'h04, 32'h00000000);
    rd(8'h08, 32'h00000000);
    rd(8'h0C, 32'h00000000);
    wr(8'h04, 32'h0000001F);
    settle;
    chk(runs, 32'h00000000);
    rd(8'h04, 32'h0000001F);
    pulse(0);
    settle;
    chk(runs, 32'h00000007);
    wr(8'h04, 32'h0000000F);
    settle;
    chk(runs, 32'h00000003);
    wr(8'h04, 32'h00000000);
    settle;
    chk(runs, 32'h00000000);
    for (int r = 0; r < 4; r++) begin
      wr(8'h04, 32'(r));
      pulse(7);
      settle;
      for (int k = 0; k <= r; k++) begin
        chk(serve, 32'h00000001);
        pulse(6);
        // Frame boundary in mid-count must not reset the count
        if (k == 0) pulse(0);
        settle;
      end
      chk(serve, 32'h00000000);
    end
    wr(8'h08, 32'h00000004);
    wr(8'h08, 32'h00000002);
    rd(8'h08, 32'h00000006);
    wr(8'h08, 32'h00030000);
    rd(8'h08, 32'h00000006);
    pulse(3);
    rd(8'h08, 32'h00000002);
    pulse(5);
    rd(8'h08, 32'h00000006);
    pulse(2);
    rd(8'h08, 32'h00000004);
    pulse(4);
    rd(8'h08, 32'h00000006);
    wr(8'h08, 32'h00000008);
    rd(8'h08, 32'h0000000E);
    chk(32'(own_seen), 32'h00000001);
    pulse(8);
    rd(8'h08, 32'h00000006);
    repeat (5) pulse(1);
    settle;
    chk(32'(over_seen), 32'h00000005);
    rd(8'h08, 32'h00010006);
    wr(8'h04, 32'h0000001F);
    t0 = cyc;
    wr(8'h08, 32'h00000001);
    settle;
    chk({31'h00000000, soft_reset_active}, 32'h00000001);
    rd(8'h08, 32'h00000001);
    wr(8'h04, 32'h0000001F);
    rd(8'h04, 32'h00000000);
    while (soft_reset_active === 1'b1 && cyc - t0 < 3000) @(posedge clock);
    chk({31'h00000000, (cyc - t0 >= 1995 && cyc - t0 <= 2005)}, 32'h00000001);
    rd(8'h08, 32'h00000000);
    rd(8'h04, 32'h00000000);
    end_of_test;
  end

  // Whole run is near 2200 cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    end_of_test;
  end
endmodule : ohci_list_control_command_regs_tb
`default_nettype wire
